/* File: src/blc_cfg.sv */
// Wishbone register bank for boost span, headroom trim and LED level code
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R01] Span bit clear: boost 7 V to 34 V
// [R02] Span bit set: boost 16 V to 43 V
// [R03] Software avoids high span on restricted variants
// [R04] Trim bits 3:0 pick headroom offset
// [R05] Offset sets low and middle comparator thresholds
// [R06] Level code: low byte plus high nibble
// [R07] Level code scales selected full-scale current
// [R08] Unscaled: current is code/4095 times full scale
// [R09] Resistor mode scales further; zero stays zero
// [R10] High nibble is bits 3:0 next register
// [R11] Registers read back; unused bits read zero
module blc_cfg (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [15:0] scale_resistor_pin,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  output var  logic        wb_err_o,
  output var  logic        boost_span_select,
  output var  logic [15:0] boost_min_mv,
  output var  logic [15:0] boost_max_mv,
  output var  logic [9:0]  low_thresh_mv,
  output var  logic [9:0]  mid_thresh_mv,
  output var  logic [11:0] led_level_code,
  output var  logic [2:0]  full_scale_current,
  output var  logic        resistor_scale_enable,
  output var  logic [15:0] sink_current_ua
);
  logic [7:0]  span_hr_q, span_hr_d;
  logic [7:0]  lvl_lo_q, lvl_lo_d;
  logic [7:0]  lvl_hi_q, lvl_hi_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [31:0] rdat_d;
  logic        ack_d, err_d;
  logic [15:0] bmin_d, bmax_d;
  logic [9:0]  low_d, mid_d, hr_mv;
  logic [11:0] code_d;
  logic        req;

  // Headroom offset for a trim code; undefined codes keep the largest offset
  function automatic logic [9:0] blc_headroom(input logic [3:0] trim);
    logic [9:0] mv;
    mv = blc_pkg::HR_460_MV;
    unique case (trim)
      blc_pkg::TRIM_460: mv = blc_pkg::HR_460_MV;
      blc_pkg::TRIM_390: mv = blc_pkg::HR_390_MV;
      blc_pkg::TRIM_320: mv = blc_pkg::HR_320_MV;
      blc_pkg::TRIM_250: mv = blc_pkg::HR_250_MV;
      blc_pkg::TRIM_180: mv = blc_pkg::HR_180_MV;
      default:           mv = blc_pkg::HR_460_MV;
    endcase
    return mv;
  endfunction : blc_headroom

  // Byte-lane 0 write merge with field mask
  function automatic logic [7:0] blc_wr(input logic [7:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel, input logic [7:0] mask);
    logic [7:0] v;
    v = old;
    if (sel[0]) begin
      v = wd[7:0] & mask;
    end
    return v;
  endfunction : blc_wr

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

  // Bus slave: one-cycle registered answer
  always_comb begin
    span_hr_d = span_hr_q;
    lvl_lo_d  = lvl_lo_q;
    lvl_hi_d  = lvl_hi_q;
    ctrl_d    = ctrl_q;
    rdat_d    = 32'h0000_0000;
    ack_d     = 1'b0;
    err_d     = 1'b0;
    if (req) begin
      ack_d = 1'b1;
      unique case (wb_adr_i)
        blc_pkg::ADDR_SPAN_HEADROOM: begin
          if (wb_we_i) begin
            span_hr_d = blc_wr(span_hr_q, wb_dat_i, wb_sel_i, blc_pkg::MASK_SPAN_HEADROOM);
          end
          rdat_d = {24'h0, span_hr_q}; // R11
        end
        blc_pkg::ADDR_LEVEL_LOW: begin
          if (wb_we_i) begin
            lvl_lo_d = blc_wr(lvl_lo_q, wb_dat_i, wb_sel_i, blc_pkg::MASK_LEVEL_LOW);
          end
          rdat_d = {24'h0, lvl_lo_q}; // R11
        end
        blc_pkg::ADDR_LEVEL_HIGH: begin
          if (wb_we_i) begin
            lvl_hi_d = blc_wr(lvl_hi_q, wb_dat_i, wb_sel_i, blc_pkg::MASK_LEVEL_HIGH);
          end
          rdat_d = {24'h0, lvl_hi_q}; // R11
        end
        blc_pkg::ADDR_CTRL: begin
          if (wb_we_i) begin
            ctrl_d = blc_wr(ctrl_q, wb_dat_i, wb_sel_i, blc_pkg::MASK_CTRL);
          end
          rdat_d = {24'h0, ctrl_q};
        end
        blc_pkg::ADDR_STATUS: begin
          rdat_d = {16'h0, sink_current_ua};
        end
        default: begin
          ack_d = 1'b0;
          err_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      span_hr_q <= blc_pkg::RST_SPAN_HEADROOM;
      lvl_lo_q  <= blc_pkg::RST_LEVEL_LOW;
      lvl_hi_q  <= blc_pkg::RST_LEVEL_HIGH;
      ctrl_q    <= blc_pkg::RST_CTRL;
      wb_dat_o  <= 32'h0000_0000;
      wb_ack_o  <= 1'b0;
      wb_err_o  <= 1'b0;
    end else begin
      span_hr_q <= span_hr_d;
      lvl_lo_q  <= lvl_lo_d;
      lvl_hi_q  <= lvl_hi_d;
      ctrl_q    <= ctrl_d;
      wb_dat_o  <= rdat_d;
      wb_ack_o  <= ack_d;
      wb_err_o  <= err_d;
    end
  end

  // Derived analogue settings
  always_comb begin
    if (span_hr_q[blc_pkg::SPAN_BIT]) begin
      bmin_d = blc_pkg::SPAN_HI_MIN_MV; // R02
      bmax_d = blc_pkg::SPAN_HI_MAX_MV; // R02
    end else begin
      bmin_d = blc_pkg::SPAN_LO_MIN_MV; // R01
      bmax_d = blc_pkg::SPAN_LO_MAX_MV; // R01
    end
    // Restricted variants: software keeps span low; hardware does not block
    hr_mv = blc_headroom(span_hr_q[blc_pkg::MARGIN_LSB +: blc_pkg::MARGIN_W]); // R04
    low_d = 10'(hr_mv + 10'(ctrl_q[blc_pkg::COARSE_LSB +: blc_pkg::COARSE_W])
                * blc_pkg::COARSE_STEP_MV); // R05
    mid_d = 10'(hr_mv + (hr_mv >> 1)); // R05
    code_d = {lvl_hi_q[blc_pkg::NIBBLE_LSB +: blc_pkg::NIBBLE_W], lvl_lo_q}; // R06 R10
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boost_span_select     <= 1'b0;
      boost_min_mv          <= blc_pkg::SPAN_LO_MIN_MV;
      boost_max_mv          <= blc_pkg::SPAN_LO_MAX_MV;
      low_thresh_mv         <= blc_pkg::HR_460_MV;
      mid_thresh_mv         <= blc_pkg::HR_460_MV;
      led_level_code        <= 12'h000;
      full_scale_current    <= 3'h0;
      resistor_scale_enable <= 1'b0;
    end else begin
      boost_span_select     <= span_hr_q[blc_pkg::SPAN_BIT];
      boost_min_mv          <= bmin_d;
      boost_max_mv          <= bmax_d;
      low_thresh_mv         <= low_d;
      mid_thresh_mv         <= mid_d;
      led_level_code        <= code_d;
      full_scale_current    <= lvl_hi_q[blc_pkg::PEAK_LSB +: blc_pkg::PEAK_W];
      resistor_scale_enable <= ctrl_q[blc_pkg::RSCALE_BIT];
    end
  end

  blc_sink_scale u_scale (
    .clk        (clk),
    .rst_b      (rst_b),
    .code       (code_d),
    .peak_sel   (lvl_hi_q[blc_pkg::PEAK_LSB +: blc_pkg::PEAK_W]),
    .rscale_en  (ctrl_q[blc_pkg::RSCALE_BIT]),
    .rscale_ohm (scale_resistor_pin),
    .sink_ua_q  (sink_current_ua)
  ); // R07 R08 R09
endmodule : blc_cfg
`default_nettype wire

/* File: src/blc_pkg.sv */
// Register map, field layout and constants for the boost and LED level configuration block
package blc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte addresses (all word aligned except ADDR_SPAN_HEADROOM at 0x9E)
  localparam logic [7:0] ADDR_SPAN_HEADROOM = 8'h9E;
  localparam logic [7:0] ADDR_LEVEL_LOW     = 8'hA0;
  localparam logic [7:0] ADDR_LEVEL_HIGH    = 8'hA4;
  localparam logic [7:0] ADDR_CTRL          = 8'hA8;
  localparam logic [7:0] ADDR_STATUS        = 8'hAC;

  // Field positions
  localparam int unsigned SPAN_BIT     = 5;
  localparam int unsigned MARGIN_LSB   = 0;
  localparam int unsigned MARGIN_W     = 4;
  localparam int unsigned NIBBLE_LSB   = 0;
  localparam int unsigned NIBBLE_W     = 4;
  localparam int unsigned PEAK_LSB     = 4;
  localparam int unsigned PEAK_W       = 3;
  localparam int unsigned COARSE_LSB   = 0;
  localparam int unsigned COARSE_W     = 3;
  localparam int unsigned RSCALE_BIT   = 4;
  localparam int unsigned CODE_W       = 12;

  // Writable masks (unused bits read zero)
  localparam logic [7:0] MASK_SPAN_HEADROOM = 8'h2F;
  localparam logic [7:0] MASK_LEVEL_LOW     = 8'hFF;
  localparam logic [7:0] MASK_LEVEL_HIGH    = 8'h7F;
  localparam logic [7:0] MASK_CTRL          = 8'h17;

  // Reset values
  localparam logic [7:0] RST_SPAN_HEADROOM = 8'h00;
  localparam logic [7:0] RST_LEVEL_LOW     = 8'h00;
  localparam logic [7:0] RST_LEVEL_HIGH    = 8'h00;
  localparam logic [7:0] RST_CTRL          = 8'h00;

  // Boost span limits in millivolts
  localparam logic [15:0] SPAN_LO_MIN_MV = 16'd7000;
  localparam logic [15:0] SPAN_LO_MAX_MV = 16'd34000;
  localparam logic [15:0] SPAN_HI_MIN_MV = 16'd16000;
  localparam logic [15:0] SPAN_HI_MAX_MV = 16'd43000;

  // Headroom trim codes and offsets in millivolts
  localparam logic [3:0] TRIM_460 = 4'h0;
  localparam logic [3:0] TRIM_390 = 4'h1;
  localparam logic [3:0] TRIM_320 = 4'h2;
  localparam logic [3:0] TRIM_250 = 4'h4;
  localparam logic [3:0] TRIM_180 = 4'h8;
  localparam logic [9:0] HR_460_MV = 10'd460;
  localparam logic [9:0] HR_390_MV = 10'd390;
  localparam logic [9:0] HR_320_MV = 10'd320;
  localparam logic [9:0] HR_250_MV = 10'd250;
  localparam logic [9:0] HR_180_MV = 10'd180;
  localparam logic [9:0] COARSE_STEP_MV = 10'd10;

  // Code full scale and resistor scaling reference (20000 x 1.2 V)
  localparam logic [11:0] CODE_FULL   = 12'hFFF;
  localparam logic [15:0] RSCALE_GAIN = 16'd24000;
  localparam logic [15:0] RSCALE_NOM  = 16'd24000;
endpackage : blc_pkg

/* File: src/blc_sink_scale.sv */
// Sink current target computed from level code, peak select and resistor scaling
`timescale 1ns/1ps
`default_nettype none
module blc_sink_scale (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] code,
  input  wire logic [2:0]  peak_sel,
  input  wire logic        rscale_en,
  input  wire logic [15:0] rscale_ohm,
  output var  logic [15:0] sink_ua_q
);
  logic [15:0] full_ua;
  logic [27:0] prod;
  logic [15:0] base_ua;
  logic [31:0] scaled;
  logic [15:0] sink_ua_d;

  // Full-scale current in microamps per peak select code
  always_comb begin
    unique case (peak_sel)
      3'h0:    full_ua = 16'd5000;
      3'h1:    full_ua = 16'd10000;
      3'h2:    full_ua = 16'd15000;
      3'h3:    full_ua = 16'd20000;
      3'h4:    full_ua = 16'd23000;
      3'h5:    full_ua = 16'd25000;
      3'h6:    full_ua = 16'd30000;
      3'h7:    full_ua = 16'd50000;
    endcase
  end

  always_comb begin
    prod    = 28'(code) * 28'(full_ua);
    base_ua = 16'(prod / 28'(blc_pkg::CODE_FULL)); // R07 R08
    scaled  = 32'(base_ua) * 32'(blc_pkg::RSCALE_GAIN);
    sink_ua_d = base_ua;
    if (rscale_en) begin
      // Zero code stays zero; zero resistance clamps to unscaled
      if (rscale_ohm != 16'h0000) begin
        sink_ua_d = 16'(scaled / 32'(rscale_ohm)); // R09
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sink_ua_q <= 16'h0000;
    end else begin
      sink_ua_q <= sink_ua_d;
    end
  end
endmodule : blc_sink_scale
`default_nettype wire

/* File: verification/blc_cfg_properties.sv */
// Checker of bus answers and derived outputs of the configuration bank
`timescale 1ns/1ps
`default_nettype none
module blc_cfg_properties (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        boost_span_select,
  input wire logic [15:0] boost_min_mv,
  input wire logic [15:0] boost_max_mv,
  input wire logic [9:0]  mid_thresh_mv,
  input wire logic [11:0] led_level_code,
  input wire logic [2:0]  full_scale_current,
  input wire logic        resistor_scale_enable,
  input wire logic [15:0] sink_current_ua
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  span_low_a: assert property (
    !boost_span_select [*2] |-> boost_min_mv == 16'd7000 && boost_max_mv == 16'd34000)
    else $error("low span limits wrong");
  span_high_a: assert property (
    boost_span_select [*2] |-> boost_min_mv == 16'd16000 && boost_max_mv == 16'd43000)
    else $error("high span limits wrong");
  mid_level_a: assert property (
    $past(rst_b) |-> mid_thresh_mv inside {10'd690, 10'd585, 10'd480, 10'd375, 10'd270})
    else $error("middle threshold off the trim set");
  zero_code_a: assert property (
    led_level_code == 12'h000 [*2] |-> sink_current_ua == 16'h0000)
    else $error("zero code gives current");
  full_code_a: assert property (
    (led_level_code == 12'hFFF && full_scale_current == 3'h7 && !resistor_scale_enable) [*2]
    |-> sink_current_ua == 16'd50000) else $error("full code not full scale");
  err_map_a: assert property (
    take && !(wb_adr_i inside {8'h9E, 8'hA0, 8'hA4, 8'hA8, 8'hAC}) |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  ack_map_a: assert property (
    take && (wb_adr_i inside {8'h9E, 8'hA0, 8'hA4, 8'hA8, 8'hAC}) |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acknowledged");
  unused_zero_a: assert property (
    wb_ack_o && !$past(wb_we_i) |->
      wb_dat_o[31:16] == 16'h0000 && ($past(wb_adr_i) == 8'hAC || wb_dat_o[15:8] == 8'h00))
    else $error("unused read bits not zero");
  cover property (wb_err_o);
  cover property (boost_span_select);
  cover property (resistor_scale_enable && sink_current_ua != 16'h0000);
endmodule : blc_cfg_properties
bind blc_cfg blc_cfg_properties u_prop (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .boost_span_select(boost_span_select),
  .boost_min_mv(boost_min_mv), .boost_max_mv(boost_max_mv), .mid_thresh_mv(mid_thresh_mv),
  .led_level_code(led_level_code), .full_scale_current(full_scale_current),
  .resistor_scale_enable(resistor_scale_enable), .sink_current_ua(sink_current_ua));
`default_nettype wire

/* File: verification/test_boost_range_led_current_cfg.sv */
// Self-checking bench for the boost span and LED level register bank
`timescale 1ns/1ps
`default_nettype none
module test_boost_range_led_current_cfg;
  logic        clk, rst_b, cyc, stb, we, err, wb_ack_o, wb_err_o;
  logic        boost_span_select, resistor_scale_enable;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rd, wb_dat_o;
  logic [15:0] rpin, boost_min_mv, boost_max_mv, sink_current_ua;
  logic [9:0]  low_thresh_mv, mid_thresh_mv;
  logic [11:0] led_level_code;
  logic [2:0]  full_scale_current;
  int          bad_count, total_checks;
  blc_cfg dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .scale_resistor_pin(rpin), .wb_dat_o,
    .wb_ack_o, .wb_err_o, .boost_span_select, .boost_min_mv, .boost_max_mv, .low_thresh_mv,
    .mid_thresh_mv, .led_level_code, .full_scale_current, .resistor_scale_enable,
    .sink_current_ua);
  always #5 clk = ~clk;
  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
      chk(32'(wb_ack_o | wb_err_o), 32'd1);
      complete_run();
    end
    rd = wb_dat_o;
    err = wb_err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(rd, {24'h000000, e});
  endtask : rdchk
  task automatic t_reset;
    rdchk(8'h9E, 8'h00);
    rdchk(8'hA0, 8'h00);
    chk(32'(boost_min_mv), 32'd7000);
    chk(32'(low_thresh_mv), 32'd460);
  endtask : t_reset
  task automatic t_span;
    // Unrestricted variant: high span is legal here
    wr(8'h9E, 8'hFF);
    rdchk(8'h9E, 8'h2F);
    chk(32'(boost_span_select), 32'd1);
    chk({boost_min_mv, boost_max_mv}, {16'd16000, 16'd43000});
    wr(8'h9E, 8'h00);
    chk({boost_min_mv, boost_max_mv}, {16'd7000, 16'd34000});
  endtask : t_span
  task automatic t_trim;
    logic [3:0] tc[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    int         hr[5] = '{460, 390, 320, 250, 180};
    for (int i = 0; i < 5; i++) begin
      wr(8'h9E, {4'h0, tc[i]});
      chk(32'(low_thresh_mv), hr[i]);
      chk(32'(mid_thresh_mv), hr[i] * 3 / 2);
    end
    wr(8'hA8, 8'h03);
    chk(32'(low_thresh_mv), 32'd210);
    wr(8'hA8, 8'h00);
  endtask : t_trim
  task automatic t_level;
    wr(8'hA0, 8'h5A);
    wr(8'hA4, 8'hA3);
    rdchk(8'hA4, 8'h23);
    chk(32'(led_level_code), 32'h35A);
    chk(32'(sink_current_ua), 858 * 15000 / 4095);
    chk(32'(full_scale_current), 32'd2);
    bus(1'b0, 8'hAC, 8'h00, 4'hF);
    chk(rd, 32'(858 * 15000 / 4095));
    bus(1'b1, 8'hA0, 8'h00, 4'hE);
    rdchk(8'hA0, 8'h5A);
  endtask : t_level
  task automatic t_full;
    int fu[8] = '{5000, 10000, 15000, 20000, 23000, 25000, 30000, 50000};
    wr(8'hA0, 8'hFF);
    for (int p = 0; p < 8; p++) begin
      wr(8'hA4, {1'b0, 3'(p), 4'hF});
      chk(32'(sink_current_ua), fu[p]);
    end
    wr(8'hA0, 8'h00);
    wr(8'hA4, 8'h00);
    chk(32'(sink_current_ua), 32'd0);
  endtask : t_full
  task automatic t_rscale;
    rpin <= 16'd12000;
    wr(8'hA8, 8'h10);
    chk(32'(resistor_scale_enable), 32'd1);
    wr(8'hA0, 8'hFF);
    wr(8'hA4, 8'h0F);
    chk(32'(sink_current_ua), 32'd10000);
    rpin <= 16'h0000;
    wr(8'hA0, 8'hFF);
    chk(32'(sink_current_ua), 32'd5000);
    wr(8'hA0, 8'h00);
    wr(8'hA4, 8'h00);
    chk(32'(sink_current_ua), 32'd0);
  endtask : t_rscale
  task automatic t_err;
    bus(1'b1, 8'h10, 8'h55, 4'hF);
    chk(32'(err), 32'd1);
    bus(1'b1, 8'hAC, 8'h55, 4'hF);
    chk(32'(err), 32'd0);
  endtask : t_err
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {cyc, stb, we, adr, dat, sel} = '0;
    rpin = 16'd20000;
    bad_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_span();
    t_trim();
    t_level();
    t_full();
    t_rscale();
    t_err();
    complete_run();
  end
endmodule : test_boost_range_led_current_cfg
`default_nettype wire
